// [rtl/serial_output_buffer.sv]
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module serial_output_buffer #(
  parameter bit HIZ_OPTION = 1'b0
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic [8:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [3:0]  prescaler_tap_i,
  input  wire logic        halt_i,
  input  wire logic        irq_request_i,
  output logic             standby_o,
  output logic             resume_to_irq_o,
  output logic             global_irq_enable_o,
  output logic             jump_test_flag_o,
  output logic             holder_empty_irq_o,
  output logic             serial_clk_o,
  output logic             serial_clk_oe_n_o,
  output logic             serial_data_o,
  output logic             serial_data_oe_n_o
);
  import swb_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [3:0]   ram [RAM_WORDS];
  logic [3:0]   first_nibble_holder;
  logic         holder_full;
  logic [3:0]   index_low_reg;
  logic [1:0]   index_high;
  logic         auto_send_select;
  logic         interactive_go;
  logic [1:0]   serial_rate_reg;
  logic         auto_running;
  logic         irq_seen;
  logic [6:0]   ram_pos;
  logic [3:0]   shifter;
  logic [1:0]   bit_cnt;
  shift_state_t sh_state;
  logic         ack;
  logic [3:0]   tap_rise;
  logic [3:0]   tap_fall;

  logic       bus_wr;
  logic       hold_wr;
  logic       idx_lo_wr;
  logic       idx_hi_wr;
  logic       ctrl_wr;
  logic       auto_start;
  logic       go_start;
  logic       go_stop;
  logic       nibble_end;
  logic       more;
  logic       load_holder;
  logic       load_ram;
  logic       finish;
  logic       rise_sel;
  logic       fall_sel;
  logic [5:0] last_index;

  function automatic logic [31:0] nib_word(input logic [3:0] n);
    nib_word = {28'h0000000, n};
  endfunction : nib_word

  swb_tap_sync u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .tap_i     (prescaler_tap_i),
    .rise_o    (tap_rise),
    .fall_o    (tap_fall)
  );

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  assign last_index = {index_high, index_low_reg};
  // Every tap, the fastest included, is served by the same engine.
  assign rise_sel   = tap_rise[serial_rate_reg];
  assign fall_sel   = tap_fall[serial_rate_reg];
  assign bus_wr     = avs_write_i & ack;
  assign hold_wr    = bus_wr & (avs_address_i == ADDR_HOLDER);
  assign idx_lo_wr  = bus_wr & (avs_address_i == ADDR_INDEX_LOW)
                      & ~auto_running;
  assign idx_hi_wr  = bus_wr & (avs_address_i == ADDR_INDEX_HIGH)
                      & ~auto_running;
  assign ctrl_wr    = bus_wr & (avs_address_i == ADDR_CTRL);
  assign auto_start = halt_i & auto_send_select & ~auto_running;
  assign go_start   = idx_hi_wr & avs_writedata_i[BIT_INTERACTIVE_GO]
                      & ~interactive_go & ~avs_writedata_i[BIT_AUTO_SEND]
                      & holder_full;
  assign go_stop    = idx_hi_wr & ~avs_writedata_i[BIT_INTERACTIVE_GO]
                      & interactive_go;
  assign nibble_end = (sh_state == SH_HIGH) & fall_sel
                      & (bit_cnt == LAST_BIT);
  // Interactive streams continue only if the holder was refilled in time.
  assign more       = auto_running ? (ram_pos <= {1'b0, last_index})
                                   : holder_full;
  assign load_ram   = nibble_end & auto_running & more;
  assign load_holder = go_start | (nibble_end & ~auto_running & more
                                   & ~go_stop);
  assign finish     = (nibble_end & ~more) | go_stop;

  // ---------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------
  // One wait state: the request is seen, then waitrequest drops for one
  // cycle, so every access completes two edges after it is raised.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & ~ack) begin
      avs_readdata_o <= 32'h00000000;
      if (avs_address_i[8]) begin
        avs_readdata_o <= nib_word(ram[avs_address_i[7:2]]);
      end else begin
        case (avs_address_i)
          ADDR_HOLDER:     avs_readdata_o <= nib_word(first_nibble_holder);
          ADDR_INDEX_LOW:  avs_readdata_o <= nib_word(index_low_reg);
          ADDR_INDEX_HIGH: avs_readdata_o <= nib_word({auto_send_select,
                                             interactive_go, index_high});
          ADDR_RATE:       avs_readdata_o <= {30'h00000000, serial_rate_reg};
          ADDR_CTRL:       avs_readdata_o <= {26'h0000000, irq_seen,
                                             standby_o,
                                             sh_state != SH_IDLE,
                                             holder_empty_irq_o,
                                             jump_test_flag_o,
                                             global_irq_enable_o};
          default:         avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (bus_wr & avs_address_i[8] & (avs_address_i[1:0] == 2'h0)) begin
      ram[avs_address_i[7:2]] <= avs_writedata_i[3:0];
    end
  end

  // ---------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      first_nibble_holder <= HOLDER_RESET;
      serial_rate_reg     <= RATE_RESET;
      index_low_reg       <= 4'h0;
      index_high          <= 2'h0;
    end else begin
      if (hold_wr) begin
        first_nibble_holder <= avs_writedata_i[3:0];
      end
      if (bus_wr & (avs_address_i == ADDR_RATE)) begin
        serial_rate_reg <= avs_writedata_i[1:0];
      end
      if (idx_lo_wr) begin
        index_low_reg <= avs_writedata_i[3:0];
      end
      if (idx_hi_wr) begin
        index_high <= avs_writedata_i[1:0];
      end
    end
  end

  // Holder occupancy: a write in the same cycle as a load keeps it full.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      holder_full <= 1'b0;
    end else if (hold_wr) begin
      holder_full <= 1'b1;
    end else if (load_holder | auto_start) begin
      holder_full <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Mode bits
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      auto_send_select <= 1'b0;
      interactive_go   <= 1'b0;
    end else if (auto_running & finish) begin
      auto_send_select <= 1'b0;
    end else if (idx_hi_wr) begin
      auto_send_select <= avs_writedata_i[BIT_AUTO_SEND];
      interactive_go   <= go_start;
    end else if (finish) begin
      interactive_go   <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      auto_running <= 1'b0;
      standby_o    <= 1'b0;
    end else if (auto_start) begin
      auto_running <= 1'b1;
      standby_o    <= 1'b1;
    end else if (auto_running & finish) begin
      auto_running <= 1'b0;
      standby_o    <= 1'b0;
    end
  end

  // An interrupt raised during the transfer is remembered so the CPU
  // enters its routine instead of resuming after the halt.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_seen        <= 1'b0;
      resume_to_irq_o <= 1'b0;
    end else if (auto_start) begin
      irq_seen        <= irq_request_i;
      resume_to_irq_o <= 1'b0;
    end else if (auto_running) begin
      irq_seen        <= irq_seen | irq_request_i;
      resume_to_irq_o <= finish & (irq_seen | irq_request_i);
    end else begin
      resume_to_irq_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      global_irq_enable_o <= 1'b0;
    end else if (auto_running & finish) begin
      // The end of a transfer wins: the select bit drops on this same edge.
      global_irq_enable_o <= 1'b1;
    end else if (auto_send_select | (idx_hi_wr
                 & avs_writedata_i[BIT_AUTO_SEND])) begin
      global_irq_enable_o <= 1'b0;
    end else if (ctrl_wr) begin
      global_irq_enable_o <= avs_writedata_i[BIT_CTRL_GIE];
    end
  end

  // ---------------------------------------------------------------------
  // Flags: a holder load, or for the jump test flag an auto end, wins over a holder write in the same cycle; the empty-holder level does not
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      jump_test_flag_o <= 1'b0;
    end else if ((auto_running & finish) | load_holder) begin
      jump_test_flag_o <= 1'b1;
    end else if (hold_wr) begin
      jump_test_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      holder_empty_irq_o <= 1'b0;
    end else if (load_holder | (interactive_go & ~holder_full
                 & ~finish & ~hold_wr)) begin
      holder_empty_irq_o <= 1'b1;
    end else if (hold_wr) begin
      holder_empty_irq_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sh_state <= SH_IDLE;
      shifter  <= 4'h0;
      bit_cnt  <= 2'h0;
      ram_pos  <= 7'h00;
    end else if (auto_start) begin
      shifter  <= first_nibble_holder;
      bit_cnt  <= 2'h0;
      ram_pos  <= 7'h00;
      sh_state <= SH_LOW;
    end else if (finish) begin
      sh_state <= SH_IDLE;
    end else if (load_holder) begin
      shifter  <= first_nibble_holder;
      bit_cnt  <= 2'h0;
      sh_state <= SH_LOW;
    end else if (load_ram) begin
      shifter  <= ram[ram_pos[5:0]];
      ram_pos  <= ram_pos + 7'h01;
      bit_cnt  <= 2'h0;
      sh_state <= SH_LOW;
    end else begin
      case (sh_state)
        SH_LOW: begin
          if (rise_sel) begin
            sh_state <= SH_HIGH;
          end
        end
        SH_HIGH: begin
          if (fall_sel) begin
            bit_cnt  <= bit_cnt + 2'h1;
            sh_state <= SH_LOW;
          end
        end
        default: sh_state <= SH_IDLE;
      endcase
    end
  end

  // Data moves with the rising clock so the receiver samples on the fall.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      serial_clk_o  <= 1'b0;
      serial_data_o <= 1'b0;
    end else if (finish | auto_start | (sh_state == SH_IDLE)) begin
      // Data lingers one cycle after a stop so it never moves with the
      // falling clock that the receiver samples on.
      serial_clk_o  <= 1'b0;
      serial_data_o <= (sh_state == SH_IDLE) ? 1'b0 : serial_data_o;
    end else if ((sh_state == SH_LOW) & rise_sel & ~load_ram
                 & ~load_holder) begin
      serial_clk_o  <= 1'b1;
      serial_data_o <= shifter[bit_cnt];
    end else if ((sh_state == SH_HIGH) & fall_sel) begin
      serial_clk_o  <= 1'b0;
    end
  end

  // With the high-impedance option the pins float outside transfers.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      serial_clk_oe_n_o  <= HIZ_OPTION;
      serial_data_oe_n_o <= HIZ_OPTION;
    end else if (auto_start | go_start) begin
      serial_clk_oe_n_o  <= 1'b0;
      serial_data_oe_n_o <= 1'b0;
    end else if (finish) begin
      serial_clk_oe_n_o  <= HIZ_OPTION;
      serial_data_oe_n_o <= HIZ_OPTION;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_gie_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
      auto_send_select |-> !global_irq_enable_o;
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("Global irq enable high during auto send.");

  property p_auto_end;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (auto_running && finish) |=> (jump_test_flag_o && !standby_o
        && global_irq_enable_o && !auto_send_select);
  endproperty
  a_auto_end: assert property (p_auto_end)
    else $error("Auto transfer end effects missing.");

  property p_first_nibble;
    @(posedge mclk_i) disable iff (!reset_n_i)
      auto_start |=> (shifter == $past(first_nibble_holder)) && standby_o;
  endproperty
  a_first_nibble: assert property (p_first_nibble)
    else $error("Auto transfer did not start with the holder.");

  property p_holder_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (hold_wr && !load_holder && !auto_running && !interactive_go)
        |=> !jump_test_flag_o && !holder_empty_irq_o;
  endproperty
  a_holder_clear: assert property (p_holder_clear)
    else $error("Holder write did not clear the flags.");

  property p_load_irq;
    @(posedge mclk_i) disable iff (!reset_n_i)
      load_holder |=> holder_empty_irq_o && jump_test_flag_o;
  endproperty
  a_load_irq: assert property (p_load_irq)
    else $error("Holder move raised no empty interrupt.");

  property p_stop_now;
    @(posedge mclk_i) disable iff (!reset_n_i)
      go_stop |=> (sh_state == SH_IDLE) && !serial_clk_o && !interactive_go;
  endproperty
  a_stop_now: assert property (p_stop_now)
    else $error("Clearing go did not stop at once.");

  property p_data_edge;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ($changed(serial_data_o) && serial_data_o) |-> $rose(serial_clk_o);
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("Serial data changed off the rising clock.");

  property p_idle_low;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ##1 ($past(sh_state) == SH_IDLE) |-> !serial_clk_o && !serial_data_o;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("Serial outputs not low outside a transfer.");

  property p_index_locked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (auto_running && bus_wr && avs_address_i == ADDR_INDEX_LOW)
        |=> $stable(index_low_reg);
  endproperty
  a_index_locked: assert property (p_index_locked)
    else $error("Index changed during auto transfer.");

  property p_drive_start;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (auto_start || go_start) |=> !serial_clk_oe_n_o && !serial_data_oe_n_o;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("Outputs not driven at transfer start.");

endmodule : serial_output_buffer

`default_nettype wire

// [rtl/swb_pkg.sv]
package swb_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ---------------------------------------------------------------------
  localparam logic [8:0] ADDR_HOLDER     = 9'h000;
  localparam logic [8:0] ADDR_INDEX_LOW  = 9'h004;
  localparam logic [8:0] ADDR_INDEX_HIGH = 9'h008;
  localparam logic [8:0] ADDR_RATE       = 9'h00c;
  localparam logic [8:0] ADDR_CTRL       = 9'h010;
  // RAM window: one nibble per word, byte address bits [7:2] index it.
  localparam logic [8:0] ADDR_RAM_BASE   = 9'h100;
  localparam int         RAM_WORDS       = 64;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_AUTO_SEND      = 3;
  localparam int BIT_INTERACTIVE_GO = 2;
  localparam int BIT_CTRL_GIE       = 0;
  localparam int BIT_CTRL_JTF       = 1;
  localparam int BIT_CTRL_IRQ       = 2;
  localparam int BIT_CTRL_BUSY      = 3;
  localparam int BIT_CTRL_STANDBY   = 4;
  localparam int BIT_CTRL_IRQ_SEEN  = 5;

  // ---------------------------------------------------------------------
  // Reset values and figures
  // ---------------------------------------------------------------------
  localparam logic [3:0] HOLDER_RESET   = 4'hf;
  localparam logic [1:0] RATE_RESET     = 2'h0;
  localparam logic [1:0] LAST_BIT       = 2'h3;
  // Rate select codes: 1024 Hz, 2048 Hz, 8192 Hz, 16384 Hz.
  localparam logic [1:0] RATE_1K        = 2'h0;
  localparam logic [1:0] RATE_16K       = 2'h3;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW  = 2'b01,
    SH_HIGH = 2'b10
  } shift_state_t;

endpackage : swb_pkg

// [rtl/swb_tap_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser for the prescaler taps; a level change counts
// only once the second and third stages agree, which filters one-cycle
// metastable glitches.
module swb_tap_sync (
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] tap_i,
  output logic      [3:0] rise_o,
  output logic      [3:0] fall_o
);

  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] stage3;
  logic [3:0] level;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
      stage3 <= 4'h0;
    end else begin
      stage1 <= tap_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      level <= 4'h0;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

  assign rise_o = stage2 & stage3 & ~level;
  assign fall_o = ~stage2 & ~stage3 & level;

endmodule : swb_tap_sync

`default_nettype wire

// [test/serial_output_buffer_test.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_output_buffer_test;
  import swb_pkg::*;
  typedef struct packed {
    logic        we;
    logic [8:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic mclk_i, reset_n_i, avs_read_i, avs_write_i, halt_i, irq_request_i;
  logic [8:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, c0, rx_count;
  logic avs_waitrequest_o, standby_o, resume_to_irq_o, global_irq_enable_o;
  logic jump_test_flag_o, holder_empty_irq_o, serial_clk_o, serial_data_o;
  logic [4:0]  tap_cnt;
  logic [63:0] rx_bits;
  logic        seen = 1'b0;
  logic [1:0]  oe_n;
  int          failures, n_checks;
  row_t        rows [14];

  serial_output_buffer i_serial_output_buffer (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .prescaler_tap_i({tap_cnt[0], tap_cnt[1], tap_cnt[3], tap_cnt[4]}),
    .halt_i(halt_i), .irq_request_i(irq_request_i), .standby_o(standby_o),
    .resume_to_irq_o(resume_to_irq_o),
    .global_irq_enable_o(global_irq_enable_o),
    .jump_test_flag_o(jump_test_flag_o),
    .holder_empty_irq_o(holder_empty_irq_o), .serial_clk_o(serial_clk_o),
    .serial_clk_oe_n_o(oe_n[1]), .serial_data_o(serial_data_o),
    .serial_data_oe_n_o(oe_n[0]));
  serial_receiver i_serial_receiver (.serial_clk_i(serial_clk_o),
    .serial_data_i(serial_data_o), .rx_bits_o(rx_bits),
    .rx_count_o(rx_count));

  // ---------------------------------------------------------------------
  // Clocks and shared tasks
  // ---------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Taps run unrelated in phase to the system clock; fastest is 160 ns.
  initial begin
    tap_cnt = '0;
    #7;
    forever #80 tap_cnt = tap_cnt + 5'h1;
  end
  always @(posedge mclk_i)
    if (halt_i === 1'b1) seen <= 1'b0;
    else if (resume_to_irq_o === 1'b1) seen <= 1'b1;

  task automatic bus(input logic we, input logic [8:0] a,
                     input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= we;
    avs_read_i      <= !we;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    tally_and_finish();
  end

  initial begin
    reset_n_i = 1'b0; avs_read_i = 1'b0; avs_write_i = 1'b0;
    avs_address_i = '0; avs_writedata_i = '0; halt_i = 1'b0;
    irq_request_i = 1'b0;
    rows = '{'{0, ADDR_HOLDER, 0, 32'hf}, '{0, ADDR_RATE, 0, 0},
      '{0, ADDR_INDEX_HIGH, 0, 0}, '{0, ADDR_CTRL, 0, 0},
      '{1, ADDR_RATE, 2, 0}, '{0, ADDR_RATE, 0, 2},
      '{1, ADDR_RATE, 3, 0}, '{0, ADDR_RATE, 0, 3},
      '{1, ADDR_INDEX_HIGH, 3, 0}, '{0, ADDR_INDEX_HIGH, 0, 3},
      '{1, ADDR_RAM_BASE + 9'h004, 32'hc, 0},
      '{0, ADDR_RAM_BASE + 9'h004, 0, 32'hc},
      '{1, ADDR_INDEX_HIGH, 0, 0}, '{0, 9'h014, 0, 0}};
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) check(q, rows[i].e);
    end
    bus(1, ADDR_HOLDER, 32'h5);
    bus(1, ADDR_RAM_BASE, 32'ha);
    bus(1, ADDR_RAM_BASE + 9'h004, 32'h3);
    bus(1, ADDR_INDEX_LOW, 32'h1);
    for (int k = 0; k < 2; k++) begin
      bus(1, ADDR_RATE, 32'h3 - k);
      bus(1, ADDR_INDEX_HIGH, 32'h8);
      check(global_irq_enable_o, 0);
      c0 = rx_count;
      irq_request_i <= (k == 0);
      halt_i <= 1'b1;
      @(posedge mclk_i);
      halt_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check(standby_o, 1);
      bus(1, ADDR_INDEX_LOW, 32'h0);
      while (standby_o !== 1'b0) @(posedge mclk_i);
      irq_request_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check(rx_count - c0, 12);
      check(rx_bits[63:52], 32'h3a5);
      check(jump_test_flag_o, 1);
      check(global_irq_enable_o, 1);
      check(seen, k == 0);
      check({serial_clk_o, serial_data_o}, 0);
      check(oe_n, 0);
      bus(0, ADDR_INDEX_HIGH, 0);
      check(q[3], 0);
      bus(1, ADDR_HOLDER, 32'h5);
      check(jump_test_flag_o, 0);
      bus(1, ADDR_INDEX_LOW, 32'h1);
    end
    bus(1, ADDR_RATE, 32'h1);
    bus(1, ADDR_HOLDER, 32'h6);
    c0 = rx_count;
    bus(1, ADDR_INDEX_HIGH, 32'h4);
    while (holder_empty_irq_o !== 1'b1) @(posedge mclk_i);
    check(jump_test_flag_o, 1);
    bus(1, ADDR_HOLDER, 32'h9);
    check({holder_empty_irq_o, jump_test_flag_o}, 0);
    q = 32'h4;
    while (q[2] !== 1'b0) bus(0, ADDR_INDEX_HIGH, 0);
    check(rx_count - c0, 8);
    check(rx_bits[63:56], 32'h96);
    bus(1, ADDR_RATE, 32'h3);
    bus(1, ADDR_HOLDER, 32'h7);
    c0 = rx_count;
    bus(1, ADDR_INDEX_HIGH, 32'h4);
    while (serial_clk_o !== 1'b1) @(posedge mclk_i);
    bus(1, ADDR_INDEX_HIGH, 32'h0);
    check(serial_clk_o, 0);
    repeat (60) @(posedge mclk_i);
    check(rx_count - c0 < 4, 1);
    tally_and_finish();
  end
endmodule : serial_output_buffer_test

`default_nettype wire

// [test/serial_receiver.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_receiver (
  input  wire logic        serial_clk_i,
  input  wire logic        serial_data_i,
  output logic      [63:0] rx_bits_o,
  output logic      [31:0] rx_count_o
);
  // ---------------------------------------------------------------------
  // Sampling on the falling serial clock
  // ---------------------------------------------------------------------
  logic [63:0] bits  = '0;
  logic [31:0] count = '0;

  assign rx_bits_o  = bits;
  assign rx_count_o = count;

  // Newest bit enters at the top, so LSB-first nibbles read back in order.
  // The bench works with count differences, so a start-up edge is harmless.
  always @(negedge serial_clk_i) begin
    bits  <= {serial_data_i, bits[63:1]};
    count <= count + 32'h1;
  end
endmodule : serial_receiver

`default_nettype wire
